// >>> hdl/wtl_trigger.sv
// waveform trigger qualification, capture and buffer control
`timescale 1ns/1ps
`default_nettype none
`include "wtl_map.svh"
module wtl_trigger #(
	parameter int AUTO_CYC = `WTL_AUTO_MS * 1000 * `WTL_CLK_MHZ
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [`WTL_SW-1:0] sample_in,
	input wire logic sample_valid_in,
	input wire wtl_pkg::wtl_type_e trig_type_in,
	input wire wtl_pkg::wtl_mode_e trig_mode_in,
	input wire wtl_pkg::wtl_dir_e dir_in,
	input wire wtl_pkg::wtl_cond_e cond_in,
	input wire logic region_out_of_range_in,
	input wire logic hyst_en_in,
	input wire logic [`WTL_SW-1:0] thresh1_in,
	input wire logic [`WTL_SW-1:0] thresh2_in,
	input wire logic [`WTL_SW-1:0] hyst_in,
	input wire logic [`WTL_TW-1:0] time1_in,
	input wire logic [`WTL_TW-1:0] time2_in,
	input wire logic [`WTL_TB_W-1:0] timebase_us_in,
	input wire logic rearm_in,
	input wire logic buf_prev_in,
	input wire logic buf_next_in,
	input wire logic [`WTL_SEG_AW-1:0] view_addr_in,
	output logic trig_out,
	output logic auto_fire_out,
	output logic capturing_out,
	output logic halted_out,
	output logic continuous_out,
	output logic trace_upd_out,
	output logic [`WTL_SW-1:0] trace_data_out,
	output logic trace_done_out,
	output logic [5:0] buf_index_out,
	output logic [5:0] buf_count_out,
	output logic [`WTL_SW-1:0] view_data_out
);
	// ------------------------------------------------------------
	// sample comparisons
	// ------------------------------------------------------------
	logic signed [`WTL_SW:0] s13, th1_13, th2_13, th_lo, th_hi;
	logic hi1, hi2, inwin, below_lo, above_hi;
	logic hi1_r, hi2_r, inwin_r, seen_r;

	assign s13 = {sample_in[`WTL_SW-1], sample_in};
	assign th1_13 = {thresh1_in[`WTL_SW-1], thresh1_in};
	assign th2_13 = {thresh2_in[`WTL_SW-1], thresh2_in};
	assign th_lo = th1_13 - $signed({1'b0, hyst_in});
	assign th_hi = th1_13 + $signed({1'b0, hyst_in});
	assign hi1 = s13 > th1_13;
	assign hi2 = s13 > th2_13;
	assign inwin = (s13 <= th1_13) && (s13 >= th2_13);
	assign below_lo = s13 < th_lo;
	assign above_hi = s13 > th_hi;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			hi1_r <= 1'b0;
			hi2_r <= 1'b0;
			inwin_r <= 1'b0;
			seen_r <= 1'b0;
		end else if (sample_valid_in) begin
			hi1_r <= hi1;
			hi2_r <= hi2;
			inwin_r <= inwin;
			seen_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// edges with optional hysteresis arming
	// ------------------------------------------------------------
	logic rise_x, fall_x, arm_up_r, arm_dn_r, use_hyst, edge_up, edge_dn;

	assign rise_x = seen_r && !hi1_r && hi1;
	assign fall_x = seen_r && hi1_r && !hi1;
	assign use_hyst = hyst_en_in && (trig_type_in != wtl_pkg::WTL_T_EDGE);
	assign edge_up = rise_x && (!use_hyst || arm_up_r);
	assign edge_dn = fall_x && (!use_hyst || arm_dn_r);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			arm_up_r <= 1'b0;
			arm_dn_r <= 1'b0;
		end else if (sample_valid_in) begin
			// rise armed below the lower level, fall above the upper, each spent on its crossing
			if (below_lo) begin
				arm_up_r <= 1'b1;
			end else if (rise_x) begin
				arm_up_r <= 1'b0;
			end
			if (above_hi) begin
				arm_dn_r <= 1'b1;
			end else if (fall_x) begin
				arm_dn_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// duration counters, in samples
	// ------------------------------------------------------------
	logic [`WTL_TW-1:0] lvl_cnt_r, lvl_cnt_nxt, win_cnt_r, win_cnt_nxt;
	logic [`WTL_TW-1:0] iv_cnt_r, iv_cnt_nxt;
	logic lvl_r, lvl_seen_r, iv_seen_r, iv_edge, win_chg;

	assign iv_edge = (dir_in == wtl_pkg::WTL_D_FALL) ? edge_dn : edge_up;
	assign win_chg = seen_r && (inwin != inwin_r);

	function automatic logic [`WTL_TW-1:0] sat_inc(
		input logic [`WTL_TW-1:0] v
	);
		sat_inc = (v == `WTL_CNT_MAX) ? v : v + 16'h0001;
	endfunction

	assign lvl_cnt_nxt = (edge_up || edge_dn) ? 16'h0001 : sat_inc(lvl_cnt_r);
	assign win_cnt_nxt = win_chg ? 16'h0001 : sat_inc(win_cnt_r);
	assign iv_cnt_nxt = iv_edge ? 16'h0001 : sat_inc(iv_cnt_r);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			lvl_cnt_r <= 16'h0000;
			lvl_r <= 1'b0;
			lvl_seen_r <= 1'b0;
		end else if (sample_valid_in) begin
			lvl_cnt_r <= lvl_cnt_nxt;
			if (edge_up || edge_dn) begin
				lvl_r <= edge_up;
				lvl_seen_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			win_cnt_r <= 16'h0000;
			iv_cnt_r <= 16'h0000;
			iv_seen_r <= 1'b0;
		end else if (sample_valid_in) begin
			win_cnt_r <= win_cnt_nxt;
			iv_cnt_r <= iv_cnt_nxt;
			if (iv_edge) begin
				iv_seen_r <= 1'b1;
			end
		end
	end

	// width condition shared by pulse width and interval
	function automatic logic cond_ok(
		input wtl_pkg::wtl_cond_e c,
		input logic [`WTL_TW-1:0] w,
		input logic [`WTL_TW-1:0] t1,
		input logic [`WTL_TW-1:0] t2
	);
		case (c)
			wtl_pkg::WTL_C_GT: cond_ok = w > t1;
			wtl_pkg::WTL_C_LT: cond_ok = w < t1;
			wtl_pkg::WTL_C_IN: cond_ok = (w > t1) && (w < t2);
			default: cond_ok = (w < t1) || (w > t2);
		endcase
	endfunction

	// ------------------------------------------------------------
	// underthrow tracking
	// ------------------------------------------------------------
	logic ut_arm_r, ut_fire;

	// positive: rose past lower, fell back before reaching upper
	assign ut_fire = ut_arm_r && ((dir_in == wtl_pkg::WTL_D_FALL) ?
		(rise_x) : (hi2_r && !hi2));

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ut_arm_r <= 1'b0;
		end else if (sample_valid_in) begin
			if (dir_in == wtl_pkg::WTL_D_FALL) begin
				if (fall_x) begin
					ut_arm_r <= 1'b1;
				end else if (!hi2 || rise_x) begin
					ut_arm_r <= 1'b0;
				end
			end else begin
				if (seen_r && !hi2_r && hi2) begin
					ut_arm_r <= 1'b1;
				end else if (hi1 || !hi2) begin
					ut_arm_r <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// trigger selection
	// ------------------------------------------------------------
	logic fire, p_end, region_now;

	// positive pulse ends on the fall, negative on the rise
	assign p_end = (dir_in == wtl_pkg::WTL_D_FALL) ? edge_up : edge_dn;
	assign region_now = region_out_of_range_in ? !inwin : inwin;

	always_comb begin
		fire = 1'b0;
		case (trig_type_in)
			wtl_pkg::WTL_T_EDGE:
				fire = (dir_in == wtl_pkg::WTL_D_FALL) ? fall_x : rise_x;
			wtl_pkg::WTL_T_ADV_EDGE: begin
				case (dir_in)
					wtl_pkg::WTL_D_RISE: fire = edge_up;
					wtl_pkg::WTL_D_FALL: fire = edge_dn;
					default: fire = edge_up || edge_dn;
				endcase
			end
			wtl_pkg::WTL_T_WINDOW: begin
				case (dir_in)
					wtl_pkg::WTL_D_RISE: fire = win_chg && inwin;
					wtl_pkg::WTL_D_FALL: fire = win_chg && !inwin;
					default: fire = win_chg;
				endcase
			end
			wtl_pkg::WTL_T_PULSE:
				fire = p_end && lvl_seen_r &&
					cond_ok(cond_in, lvl_cnt_r, time1_in, time2_in);
			wtl_pkg::WTL_T_INTERVAL:
				fire = iv_edge && iv_seen_r &&
					cond_ok(cond_in, iv_cnt_r, time1_in, time2_in);
			wtl_pkg::WTL_T_WIN_PULSE:
				fire = seen_r && region_now && (win_cnt_nxt == time1_in);
			wtl_pkg::WTL_T_HORIZ:
				fire = lvl_seen_r && !(edge_up || edge_dn) &&
					(lvl_r == (dir_in != wtl_pkg::WTL_D_FALL)) &&
					(lvl_cnt_nxt == time1_in + 16'h0001);
			wtl_pkg::WTL_T_WIN_DIST:
				fire = seen_r && inwin && (win_cnt_nxt == time1_in);
			wtl_pkg::WTL_T_UNDER:
				fire = ut_fire;
			default:
				fire = 1'b0;
		endcase
		fire = fire && sample_valid_in;
	end

	// ------------------------------------------------------------
	// acquisition control
	// ------------------------------------------------------------
	wtl_pkg::wtl_state_e state_r;
	logic [31:0] auto_cnt_r;
	logic [`WTL_SEG_AW-1:0] wpos_r;
	logic [`WTL_SLOT_AW-1:0] slot_r, sel_r;
	logic [5:0] count_r;
	logic auto_go, start, seg_done;

	assign auto_go = (trig_mode_in == wtl_pkg::WTL_M_AUTO) &&
		(auto_cnt_r == AUTO_CYC - 1);
	// free-running mode starts without a trigger
	assign start = fire || auto_go ||
		(trig_mode_in == wtl_pkg::WTL_M_NONE);
	assign seg_done = sample_valid_in && (wpos_r == `WTL_SEG_LAST);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_r <= wtl_pkg::WTL_S_WAIT;
		end else begin
			case (state_r)
				wtl_pkg::WTL_S_WAIT:
					if (start) begin
						state_r <= wtl_pkg::WTL_S_CAPT;
					end
				wtl_pkg::WTL_S_CAPT:
					if (seg_done) begin
						if (trig_mode_in == wtl_pkg::WTL_M_SINGLE) begin
							state_r <= wtl_pkg::WTL_S_HALT;
						end else begin
							state_r <= wtl_pkg::WTL_S_WAIT;
						end
					end
				default:
					if (rearm_in) begin
						state_r <= wtl_pkg::WTL_S_WAIT;
					end
			endcase
		end
	end

	// auto mode: timed update when no trigger comes
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			auto_cnt_r <= 32'h0000_0000;
		end else if (state_r != wtl_pkg::WTL_S_WAIT || start) begin
			auto_cnt_r <= 32'h0000_0000;
		end else begin
			auto_cnt_r <= auto_cnt_r + 32'h0000_0001;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			wpos_r <= 6'h00;
		end else if (state_r == wtl_pkg::WTL_S_CAPT && sample_valid_in) begin
			wpos_r <= wpos_r + 6'h01;
		end else if (state_r != wtl_pkg::WTL_S_CAPT) begin
			wpos_r <= 6'h00;
		end
	end

	// ------------------------------------------------------------
	// waveform buffer and navigation
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			slot_r <= 5'h00;
			count_r <= 6'h00;
			sel_r <= 5'h00;
		end else if (state_r == wtl_pkg::WTL_S_CAPT && seg_done) begin
			slot_r <= slot_r + 5'h01;
			sel_r <= slot_r;
			if (count_r != `WTL_NSLOT) begin
				count_r <= count_r + 6'h01;
			end
		end else if (buf_prev_in && sel_r != 5'h00) begin
			sel_r <= sel_r - 5'h01;
		end else if (buf_next_in && {1'b0, sel_r} + 6'h01 < count_r) begin
			sel_r <= sel_r + 5'h01;
		end
	end

	wtl_mem_if mbus ();

	assign mbus.wr_en = (state_r == wtl_pkg::WTL_S_CAPT) && sample_valid_in;
	assign mbus.wr_addr = {slot_r, wpos_r};
	assign mbus.wr_data = sample_in;
	assign mbus.rd_addr = {sel_r, view_addr_in};

	wtl_wave_mem u_mem (
		.mclk_in(mclk_in),
		.mp(mbus.mem)
	);

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	logic [`WTL_SW-1:0] view_r;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			view_r <= 12'h000;
		end else begin
			view_r <= mbus.rd_data;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			trig_out <= 1'b0;
			auto_fire_out <= 1'b0;
			capturing_out <= 1'b0;
			halted_out <= 1'b0;
			buf_index_out <= 6'h00;
			buf_count_out <= 6'h00;
		end else begin
			trig_out <= fire;
			auto_fire_out <= auto_go && !fire && state_r == wtl_pkg::WTL_S_WAIT;
			capturing_out <= state_r == wtl_pkg::WTL_S_CAPT;
			halted_out <= state_r == wtl_pkg::WTL_S_HALT;
			// index shown one-based, zero while empty
			buf_index_out <= (count_r == 6'h00) ? 6'h00 :
				{1'b0, sel_r} + 6'h01;
			buf_count_out <= count_r;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			continuous_out <= 1'b0;
			trace_upd_out <= 1'b0;
			trace_data_out <= 12'h000;
			trace_done_out <= 1'b0;
		end else begin
			continuous_out <= timebase_us_in >= `WTL_CONT_US;
			// slow timebases stream each stored sample to the trace
			trace_upd_out <= mbus.wr_en && continuous_out;
			trace_data_out <= sample_in;
			trace_done_out <= state_r == wtl_pkg::WTL_S_CAPT && seg_done;
		end
	end

	assign view_data_out = view_r;
endmodule
`default_nettype wire

// >>> hdl/wtl_map.svh
// constants for the waveform trigger block
`ifndef WTL_MAP_SVH
`define WTL_MAP_SVH
`define WTL_SW 12
`define WTL_TW 16
`define WTL_SEG_AW 6
`define WTL_SLOT_AW 5
`define WTL_MEM_AW 11
`define WTL_NSLOT 6'h20
`define WTL_TB_W 32
`define WTL_CONT_US 32'h0003_0D40
`define WTL_CLK_MHZ 250
`define WTL_AUTO_MS 100
`define WTL_CNT_MAX 16'hFFFF
`define WTL_SEG_LAST 6'h3F
`endif

// >>> hdl/wtl_pkg.sv
// types for the waveform trigger block
package wtl_pkg;
	typedef enum logic [3:0] {
		WTL_T_EDGE, WTL_T_ADV_EDGE, WTL_T_WINDOW, WTL_T_PULSE, WTL_T_INTERVAL,
		WTL_T_WIN_PULSE, WTL_T_HORIZ, WTL_T_WIN_DIST, WTL_T_UNDER
	} wtl_type_e;
	typedef enum logic [1:0] {WTL_D_RISE, WTL_D_FALL, WTL_D_EITHER} wtl_dir_e;
	typedef enum logic [1:0] {WTL_C_GT, WTL_C_LT, WTL_C_IN, WTL_C_OUT} wtl_cond_e;
	typedef enum logic [1:0] {WTL_M_NONE, WTL_M_AUTO, WTL_M_REPEAT,
		WTL_M_SINGLE} wtl_mode_e;
	typedef enum logic [1:0] {WTL_S_WAIT, WTL_S_CAPT, WTL_S_HALT} wtl_state_e;
endpackage

// >>> hdl/wtl_mem_if.sv
// waveform buffer memory port bundle
`timescale 1ns/1ps
`default_nettype none
`include "wtl_map.svh"
interface wtl_mem_if;
	logic wr_en;
	logic [`WTL_MEM_AW-1:0] wr_addr;
	logic [`WTL_SW-1:0] wr_data;
	logic [`WTL_MEM_AW-1:0] rd_addr;
	logic [`WTL_SW-1:0] rd_data;
	modport ctl (output wr_en, output wr_addr, output wr_data,
		output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data,
		input rd_addr, output rd_data);
endinterface
`default_nettype wire

// >>> hdl/wtl_wave_mem.sv
// waveform buffer storage, registered read
`timescale 1ns/1ps
`default_nettype none
`include "wtl_map.svh"
module wtl_wave_mem (
	input wire logic mclk_in,
	wtl_mem_if.mem mp
);
	logic [`WTL_SW-1:0] store [0:(1<<`WTL_MEM_AW)-1];
	logic [`WTL_SW-1:0] rd_r;

	always_ff @(posedge mclk_in) begin
		if (mp.wr_en) begin
			store[mp.wr_addr] <= mp.wr_data;
		end
	end

	always_ff @(posedge mclk_in) begin
		rd_r <= store[mp.rd_addr];
	end

	assign mp.rd_data = rd_r;
endmodule
`default_nettype wire

// >>> dv/wtl_src_model.sv
// sample stream source standing in for the channel front end
`timescale 1ns/1ps
`default_nettype none
`include "wtl_map.svh"
module wtl_src_model (
	input wire logic mclk_in,
	output logic [`WTL_SW-1:0] sample_out,
	output logic valid_out
);
	initial begin
		sample_out = '0;
		valid_out = 1'b0;
	end
	// n samples, optionally slow with an idle cycle after each
	task automatic send(input logic [`WTL_SW-1:0] v, input int n,
		input bit gap = 1'b0);
		repeat (n) begin
			@(negedge mclk_in);
			sample_out = v;
			valid_out = 1'b1;
			if (gap) begin
				@(negedge mclk_in);
				sample_out = ~v;
				valid_out = 1'b0;
			end
		end
	endtask
	// released lines show the inverse of the last value
	task automatic idle;
		@(negedge mclk_in);
		sample_out = ~sample_out;
		valid_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> dv/wtl_trigger_props.sv
// concurrent property checker for the waveform trigger block
`timescale 1ns/1ps
`default_nettype none
`include "wtl_map.svh"
module wtl_trigger_props #(
	parameter int AUTO_CYC = 50
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [`WTL_SW-1:0] sample_in,
	input wire logic sample_valid_in,
	input wire wtl_pkg::wtl_type_e trig_type_in,
	input wire wtl_pkg::wtl_dir_e dir_in,
	input wire logic [`WTL_SW-1:0] thresh1_in,
	input wire logic [`WTL_TB_W-1:0] timebase_us_in,
	input wire logic rearm_in,
	input wire logic trig_out,
	input wire logic auto_fire_out,
	input wire logic capturing_out,
	input wire logic halted_out,
	input wire logic continuous_out,
	input wire logic trace_upd_out,
	input wire logic trace_done_out,
	input wire logic [5:0] buf_index_out,
	input wire logic [5:0] buf_count_out
);
	logic [`WTL_SW-1:0] prev_r;
	logic have_r;
	logic rise_w;
	logic edge_rise_w;
	// last valid sample, for crossing detection
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			have_r <= 1'b0;
			prev_r <= '0;
		end else if (sample_valid_in) begin
			have_r <= 1'b1;
			prev_r <= sample_in;
		end
	end
	assign rise_w = sample_valid_in && have_r &&
		$signed(prev_r) <= $signed(thresh1_in) &&
		$signed(sample_in) > $signed(thresh1_in);
	assign edge_rise_w = trig_type_in == wtl_pkg::WTL_T_EDGE &&
		dir_in == wtl_pkg::WTL_D_RISE;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	sequence s_start;
		trig_out && !capturing_out && !halted_out && !trace_done_out &&
			!$past(trace_done_out) && !$past(trace_done_out, 2);
	endsequence
	sequence s_capt_soon;
		##[0:1] capturing_out;
	endsequence
	AST_EDGE_FIRE: assert property (edge_rise_w && rise_w |=> trig_out)
		else $error("edge crossing gave no trigger");
	AST_EDGE_QUIET: assert property (edge_rise_w && !rise_w |=> !trig_out)
		else $error("edge trigger without crossing");
	AST_NOVALID: assert property (!sample_valid_in |=> !trig_out)
		else $error("trigger without a valid sample");
	AST_CONT: assert property (1'b1 |=> continuous_out ==
		($past(timebase_us_in) >= `WTL_CONT_US))
		else $error("continuous flag disagrees with timebase");
	AST_DONE_ONE: assert property (trace_done_out |=> !trace_done_out)
		else $error("capture done longer than one cycle");
	AST_CNT_STEP: assert property (trace_done_out &&
		buf_count_out != `WTL_NSLOT |-> ##[0:2] $changed(buf_count_out))
		else $error("stored count did not advance");
	AST_CNT_RANGE: assert property (buf_count_out <= `WTL_NSLOT &&
		buf_index_out <= buf_count_out)
		else $error("buffer index or count out of range");
	AST_HALT_HOLD: assert property (halted_out && !rearm_in &&
		!$past(rearm_in) |=> halted_out)
		else $error("halt left without rearm");
	AST_HALT_IDLE: assert property (halted_out |-> !capturing_out)
		else $error("capturing while halted");
	AST_TRIG_CAPT: assert property (s_start |=> capturing_out)
		else $error("trigger in wait did not start capture");
	AST_AUTO_CAPT: assert property (auto_fire_out |-> s_capt_soon)
		else $error("auto timeout did not start capture");
	AST_UPD_CONT: assert property (trace_upd_out |-> continuous_out)
		else $error("trace update outside continuous mode");
endmodule
bind wtl_trigger wtl_trigger_props #(.AUTO_CYC(AUTO_CYC)) wtl_trigger_props_i (
	.mclk_in(mclk_in), .rst_in(rst_in), .sample_in(sample_in),
	.sample_valid_in(sample_valid_in), .trig_type_in(trig_type_in),
	.dir_in(dir_in), .thresh1_in(thresh1_in),
	.timebase_us_in(timebase_us_in), .rearm_in(rearm_in),
	.trig_out(trig_out), .auto_fire_out(auto_fire_out),
	.capturing_out(capturing_out), .halted_out(halted_out),
	.continuous_out(continuous_out), .trace_upd_out(trace_upd_out),
	.trace_done_out(trace_done_out), .buf_index_out(buf_index_out),
	.buf_count_out(buf_count_out));
`default_nettype wire

// >>> dv/wtl_trigger_tb.sv
// self-checking bench for the waveform trigger block
`timescale 1ns/1ps
`default_nettype none
`include "wtl_map.svh"
module wtl_trigger_tb;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [`WTL_SW-1:0] smp, tdata, vdata;
	logic vld, trig, afire, capt, halt, cont, upd, done;
	logic [5:0] bidx, bcnt;
	wtl_pkg::wtl_type_e typ = wtl_pkg::WTL_T_EDGE;
	wtl_pkg::wtl_mode_e mode = wtl_pkg::WTL_M_REPEAT;
	wtl_pkg::wtl_dir_e dir = wtl_pkg::WTL_D_RISE;
	wtl_pkg::wtl_cond_e cond = wtl_pkg::WTL_C_GT;
	logic reg_out = 1'b0;
	logic hyst_en = 1'b0;
	logic rearm = 1'b0;
	logic prv = 1'b0;
	logic nxt = 1'b0;
	logic [5:0] vaddr = 6'h05;
	logic [`WTL_TW-1:0] t1 = 16'h0004;
	logic [`WTL_TB_W-1:0] tbase = 32'h0000_0005;
	int fail_count = 0;
	int check_count = 0;
	int n_trig, n_auto, n_upd, n_done;
	always #2 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		n_trig += int'(trig === 1'b1);
		n_auto += int'(afire === 1'b1);
		n_upd += int'(upd === 1'b1);
		n_done += int'(done === 1'b1);
	end
	wtl_src_model wtl_src_model_i (.mclk_in(mclk_in), .sample_out(smp),
		.valid_out(vld));
	wtl_trigger #(.AUTO_CYC(50)) wtl_trigger_i (.mclk_in(mclk_in),
		.rst_in(rst_in), .sample_in(smp), .sample_valid_in(vld),
		.trig_type_in(typ), .trig_mode_in(mode), .dir_in(dir),
		.cond_in(cond), .region_out_of_range_in(reg_out),
		.hyst_en_in(hyst_en), .thresh1_in(12'h064), .thresh2_in(12'hF9C),
		.hyst_in(12'h032), .time1_in(t1), .time2_in(16'h0006),
		.timebase_us_in(tbase), .rearm_in(rearm), .buf_prev_in(prv),
		.buf_next_in(nxt), .view_addr_in(vaddr), .trig_out(trig),
		.auto_fire_out(afire), .capturing_out(capt), .halted_out(halt),
		.continuous_out(cont), .trace_upd_out(upd), .trace_data_out(tdata),
		.trace_done_out(done), .buf_index_out(bidx), .buf_count_out(bcnt),
		.view_data_out(vdata));
	task automatic chk(input string nm, input logic [15:0] got,
		input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic restart(input wtl_pkg::wtl_type_e ty,
		input wtl_pkg::wtl_dir_e d, input wtl_pkg::wtl_mode_e m);
		@(negedge mclk_in);
		rst_in = 1'b1;
		typ = ty;
		dir = d;
		mode = m;
		repeat (6) @(negedge mclk_in);
		rst_in = 1'b0;
		{n_trig, n_auto, n_upd, n_done} = '0;
	endtask
	task automatic tx(input logic [11:0] v, input int n, input bit g = 0);
		wtl_src_model_i.send(v, n, g);
	endtask
	task automatic tally(input string nm, input int exp);
		wtl_src_model_i.idle();
		repeat (4) @(negedge mclk_in);
		chk(nm, n_trig[15:0], exp[15:0]);
	endtask
	task automatic wait_n(input int t);
		int i;
		for (i = 0; i < 400 && n_done < t; i++) @(negedge mclk_in);
		if (n_done < t) begin
			$display("[FAIL] capture done expected %0d seen %0d", t, n_done);
			fail_count++;
			give_verdict();
		end
		repeat (5) @(negedge mclk_in);
	endtask
	task automatic hit(ref logic s);
		@(negedge mclk_in);
		s = 1'b1;
		@(negedge mclk_in);
		s = 1'b0;
		repeat (5) @(negedge mclk_in);
	endtask
	task automatic t_edge;
		int ex[3] = '{2, 1, 2};
		for (int d = 0; d < 3; d++) begin
			restart(wtl_pkg::WTL_T_EDGE, wtl_pkg::wtl_dir_e'(d),
				wtl_pkg::WTL_M_REPEAT);
			tx(12'h000, 1); tx(12'h0C8, 1); tx(12'h000, 1); tx(12'h0C8, 1);
			tally("edge", ex[d]);
		end
		$display("edge test done");
	endtask
	task automatic t_adv;
		restart(wtl_pkg::WTL_T_ADV_EDGE, wtl_pkg::WTL_D_EITHER,
			wtl_pkg::WTL_M_REPEAT);
		tx(12'h000, 1); tx(12'h0C8, 1); tx(12'h000, 1); tx(12'h0C8, 1);
		tally("dual edge", 3);
		for (int h = 0; h < 2; h++) begin
			restart(wtl_pkg::WTL_T_ADV_EDGE, wtl_pkg::WTL_D_RISE,
				wtl_pkg::WTL_M_REPEAT);
			hyst_en = h[0];
			tx(12'h03C, 1); tx(12'h06E, 1); tx(12'h03C, 1); tx(12'h06E, 1);
			tx(12'h000, 1); tx(12'h06E, 1);
			tally("hysteresis", h ? 1 : 3);
		end
		hyst_en = 1'b0;
		$display("advanced edge test done");
	endtask
	task automatic t_window;
		int ex[3] = '{2, 1, 3};
		for (int d = 0; d < 3; d++) begin
			restart(wtl_pkg::WTL_T_WINDOW, wtl_pkg::wtl_dir_e'(d),
				wtl_pkg::WTL_M_REPEAT);
			tx(12'hF38, 1); tx(12'h000, 1); tx(12'hF38, 1); tx(12'h000, 1);
			tally("window", ex[d]);
		end
		$display("window test done");
	endtask
	task automatic t_pulse;
		int ex[2][4] = '{'{1, 1, 0, 2}, '{1, 1, 1, 1}};
		for (int k = 0; k < 2; k++) begin
			for (int c = 0; c < 4; c++) begin
				restart(k ? wtl_pkg::WTL_T_INTERVAL : wtl_pkg::WTL_T_PULSE,
					wtl_pkg::WTL_D_RISE, wtl_pkg::WTL_M_REPEAT);
				cond = wtl_pkg::wtl_cond_e'(c);
				tx(12'h000, 1); tx(12'h0C8, 2, c[0]); tx(12'h000, 1);
				tx(12'h0C8, 4); tx(12'h000, 1); tx(12'h0C8, 8); tx(12'h000, 1);
				tally("pulse family", ex[k][c]);
			end
		end
		restart(wtl_pkg::WTL_T_PULSE, wtl_pkg::WTL_D_FALL,
			wtl_pkg::WTL_M_REPEAT);
		cond = wtl_pkg::WTL_C_GT;
		tx(12'h0C8, 1); tx(12'h000, 2); tx(12'h0C8, 1); tx(12'h000, 4);
		tx(12'h0C8, 1); tx(12'h000, 8); tx(12'h0C8, 1);
		tally("negative pulse", 1);
		$display("pulse test done");
	endtask
	task automatic t_level;
		wtl_pkg::wtl_type_e ty[5] = '{wtl_pkg::WTL_T_HORIZ,
			wtl_pkg::WTL_T_HORIZ, wtl_pkg::WTL_T_WIN_PULSE,
			wtl_pkg::WTL_T_WIN_PULSE, wtl_pkg::WTL_T_WIN_DIST};
		int ex[5] = '{1, 0, 2, 1, 2};
		for (int k = 0; k < 5; k++) begin
			restart(ty[k], k == 1 ? wtl_pkg::WTL_D_FALL : wtl_pkg::WTL_D_RISE,
				wtl_pkg::WTL_M_REPEAT);
			reg_out = (k == 3);
			t1 = (k < 2) ? 16'h0004 : 16'h0003;
			if (k < 2) begin
				tx(12'h000, 1); tx(12'h0C8, 4); tx(12'h000, 1);
				tx(12'h0C8, 8); tx(12'h000, 1);
			end else begin
				tx(12'h000, 3); tx(12'h0C8, 3); tx(12'h000, 3); tx(12'h0C8, 1);
			end
			tally("level hold", ex[k]);
		end
		{reg_out, t1} = {1'b0, 16'h0004};
		$display("level hold test done");
	endtask
	task automatic t_under;
		for (int d = 0; d < 2; d++) begin
			restart(wtl_pkg::WTL_T_UNDER, wtl_pkg::wtl_dir_e'(d),
				wtl_pkg::WTL_M_REPEAT);
			tx(d ? 12'h0C8 : 12'hF38, 1); tx(12'h000, 1);
			tx(d ? 12'h0C8 : 12'hF38, 1); tx(12'h000, 1);
			tx(d ? 12'hF38 : 12'h0C8, 1); tx(d ? 12'h0C8 : 12'hF38, 1);
			tally("underthrow", 1);
		end
		$display("underthrow test done");
	endtask
	task automatic t_buffer;
		restart(wtl_pkg::WTL_T_EDGE, wtl_pkg::WTL_D_RISE,
			wtl_pkg::WTL_M_SINGLE);
		tx(12'h000, 1); tx(12'h0AB, 70); wait_n(1);
		chk("halted", {15'h0, halt}, 16'h0001);
		tx(12'h000, 1); tx(12'h0AB, 70);
		chk("count while halted", {10'h0, bcnt}, 16'h0001);
		mode = wtl_pkg::WTL_M_REPEAT;
		hit(rearm);
		chk("rearmed", {15'h0, halt}, 16'h0000);
		tx(12'h000, 1); tx(12'h0CD, 70); wait_n(2);
		chk("count", {10'h0, bcnt}, 16'h0002);
		chk("index", {10'h0, bidx}, 16'h0002);
		chk("view new", {4'h0, vdata}, 16'h00CD);
		for (int k = 0; k < 4; k++) begin
			if (k < 2) hit(prv);
			else hit(nxt);
			chk("step index", {10'h0, bidx}, k < 2 ? 16'h0001 : 16'h0002);
		end
		vaddr = 6'h3F;
		hit(prv);
		chk("view old", {4'h0, vdata}, 16'h00AB);
		vaddr = 6'h05;
		$display("buffer test done");
	endtask
	task automatic t_auto;
		tbase = `WTL_CONT_US;
		restart(wtl_pkg::WTL_T_EDGE, wtl_pkg::WTL_D_RISE, wtl_pkg::WTL_M_AUTO);
		tx(12'h010, 130);
		chk("auto fires", n_auto[15:0], 16'h0001);
		chk("auto capture", n_done[15:0], 16'h0001);
		chk("trace updates", n_upd[15:0], 16'h0040);
		chk("trace data", {4'h0, tdata}, 16'h0010);
		chk("continuous", {15'h0, cont}, 16'h0001);
		tbase = 32'h0003_0D3F;
		repeat (3) @(negedge mclk_in);
		chk("not continuous", {15'h0, cont}, 16'h0000);
		restart(wtl_pkg::WTL_T_EDGE, wtl_pkg::WTL_D_RISE, wtl_pkg::WTL_M_NONE);
		tx(12'h010, 70); wait_n(1);
		chk("free run capturing", {15'h0, capt}, 16'h0001);
		chk("free run updates", n_upd[15:0], 16'h0000);
		$display("mode test done");
	endtask
	initial begin
		t_edge();
		t_adv();
		t_window();
		t_pulse();
		t_level();
		t_under();
		t_buffer();
		t_auto();
		give_verdict();
	end
endmodule
`default_nettype wire
